// [mri_pkg.sv]
// Package with constants and types for the message interrupt request block.
package mri_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] MRI_OFF_CSR = 12'h000;
  localparam logic [11:0] MRI_OFF_CTRL = 12'h004;
  localparam logic [11:0] MRI_OFF_STATUS = 12'h008;
  localparam logic [11:0] MRI_OFF_MASK = 12'h00c;
  localparam logic [11:0] MRI_OFF_LAST = 12'h010;
  localparam logic [11:0] MRI_OFF_MSGDATA = 12'h014;

  // ----------------------------------------------------------------------
  // Control/status field layout
  // ----------------------------------------------------------------------
  localparam int MRI_CSR_PVM_BIT = 8;
  localparam int MRI_CSR_A64_BIT = 7;
  localparam int MRI_CSR_MME_LSB = 4;
  localparam int MRI_CSR_MMC_LSB = 1;
  localparam int MRI_CSR_EN_BIT = 0;
  localparam logic [2:0] MRI_MME_RESERVED = 3'h7;
  localparam logic [2:0] MRI_MME_MAX = 3'h5;
  localparam logic [2:0] MRI_MMC_REQUESTED = 3'h3;
  localparam logic MRI_PVM_CAPABLE = 1'b1;
  localparam logic MRI_A64_CAPABLE = 1'b1;
  localparam logic [15:0] MRI_CSR_RESET = 16'h0000;

  // Control register: bit0 send hot-plug/pm, bit1 system error, bit2 gie.
  localparam int MRI_CTRL_PM_BIT = 0;
  localparam int MRI_CTRL_SERR_BIT = 1;
  localparam int MRI_CTRL_GIE_BIT = 2;
  localparam logic [31:0] MRI_CTRL_RESET = 32'h0000_0004;

  // Status bits: sent, legacy assert, legacy deassert, vector clipped.
  localparam int MRI_ST_SENT = 0;
  localparam int MRI_ST_LEG_ON = 1;
  localparam int MRI_ST_LEG_OFF = 2;
  localparam int MRI_ST_CLIP = 3;
  localparam int MRI_ST_W = 4;

  localparam int MRI_MAX_VECTORS = 32;
  localparam logic [2:0] MRI_TC_ZERO = 3'h0;
  localparam logic [1:0] MRI_SRC_APP = 2'h0;
  localparam logic [1:0] MRI_SRC_PM = 2'h1;
  localparam logic [1:0] MRI_SRC_SERR = 2'h2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] tc;
    logic [4:0] vector;
    logic [1:0] src;
  } mri_msg_s;

  typedef enum logic [1:0] {
    MRI_IDLE,
    MRI_SEND,
    MRI_ACK,
    MRI_WAIT_DROP
  } mri_state_e;

endpackage

// [mri_sync.sv]
// Two-stage synchroniser for a single level from outside the clock domain.
`timescale 1ns/1ps
module mri_sync
  import mri_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);

  logic stage1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stage1 <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      stage1 <= d;
      q <= stage1;
    end
  end

endmodule // mri_sync

// [mri_core.sv]
// Message interrupt request handler with APB registers and legacy status.
`timescale 1ns/1ps
module mri_core
  import mri_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irq_msg_req,
  input wire logic [2:0] irq_msg_traffic_class,
  input wire logic [4:0] irq_msg_vector,
  input wire logic [4:0] irq_pm_vector,
  input wire logic irq_legacy_status,
  output logic irq_msg_ack,
  output logic [15:0] msg_interrupt_control_status,
  output logic msg_valid,
  output logic [31:0] msg_data,
  output logic [2:0] msg_tc,
  output logic legacy_msg_valid,
  output logic legacy_msg_assert,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [2:0] mme, next_mme;
  logic msi_enable, next_msi_enable;
  logic [31:0] ctrl, next_ctrl;
  logic [15:0] base_data, next_base_data;
  logic [MRI_ST_W-1:0] status, next_status;
  logic [MRI_ST_W-1:0] mask, next_mask;
  mri_msg_s last;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr, next_irq;

  // ----------------------------------------------------------------------
  // Message state
  // ----------------------------------------------------------------------
  mri_state_e state, next_state;
  mri_msg_s cur, next_cur;
  logic pm_pend, serr_pend, next_pm_pend, next_serr_pend;
  logic next_ack, next_msg_valid;
  logic [31:0] next_msg_data;
  logic [2:0] next_msg_tc;
  mri_msg_s next_last;
  logic [15:0] next_csr;
  logic leg_sync, leg_prev;
  logic next_leg_valid, next_leg_assert, clip_evt;

  logic wr_en, rd_en;
  logic [4:0] alloc_mask;
  logic [4:0] vec_clipped;

  mri_sync u_leg_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(irq_legacy_status),
    .q(leg_sync)
  );

  assign wr_en = psel && penable && pwrite && !pready;
  assign rd_en = psel && penable && !pwrite && !pready;

  // ----------------------------------------------------------------------
  // Vector allocation
  // ----------------------------------------------------------------------
  always_comb
  begin
    // Honour the allocated count; reserved codes clamp to the maximum.
    // allocated count
    case (mme)
      3'h0: alloc_mask = 5'h00;
      3'h1: alloc_mask = 5'h01;
      3'h2: alloc_mask = 5'h03;
      3'h3: alloc_mask = 5'h07;
      3'h4: alloc_mask = 5'h0f;
      default: alloc_mask = 5'h1f;
    endcase
  end

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_mme = mme;
    next_msi_enable = msi_enable;
    next_ctrl = ctrl;
    next_base_data = base_data;
    next_mask = mask;
    next_prdata = 32'h0000_0000;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_status = status;
    if (psel && penable && !pready)
    begin
      next_pready = 1'b1;
    end
    if (wr_en)
    begin
      unique case (paddr)
        MRI_OFF_CSR:
        begin
          // Reserved allocation code is ignored, keeping the old value.
          // software write
          if (pwdata[MRI_CSR_MME_LSB +: 3] != MRI_MME_RESERVED)
          begin
            next_mme = pwdata[MRI_CSR_MME_LSB +: 3];
          end
          next_msi_enable = pwdata[MRI_CSR_EN_BIT];
        end
        MRI_OFF_CTRL: next_ctrl = pwdata;
        MRI_OFF_STATUS: next_status = status & ~pwdata[MRI_ST_W-1:0];
        MRI_OFF_MASK: next_mask = pwdata[MRI_ST_W-1:0];
        MRI_OFF_MSGDATA: next_base_data = pwdata[15:0];
        MRI_OFF_LAST: next_pslverr = 1'b1;
        default: next_pslverr = 1'b1;
      endcase
    end
    if (rd_en)
    begin
      unique case (paddr)
        MRI_OFF_CSR: next_prdata = {16'h0000, msg_interrupt_control_status};
        MRI_OFF_CTRL: next_prdata = ctrl;
        MRI_OFF_STATUS: next_prdata = {28'h0000_000, status};
        MRI_OFF_MASK: next_prdata = {28'h0000_000, mask};
        MRI_OFF_LAST: next_prdata = {22'h00_0000, last};
        MRI_OFF_MSGDATA: next_prdata = {16'h0000, base_data};
        default: next_pslverr = 1'b1;
      endcase
    end
    // Hardware events win over a simultaneous write-one clear.
    if (msg_valid)
    begin
      next_status[MRI_ST_SENT] = 1'b1;
    end
    if (leg_sync && !leg_prev)
    begin
      next_status[MRI_ST_LEG_ON] = 1'b1;
    end
    if (!leg_sync && leg_prev)
    begin
      next_status[MRI_ST_LEG_OFF] = 1'b1;
    end
    if (clip_evt)
    begin
      next_status[MRI_ST_CLIP] = 1'b1;
    end
    next_irq = |(next_status & mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mme <= MRI_CSR_RESET[MRI_CSR_MME_LSB +: 3];
      msi_enable <= MRI_CSR_RESET[MRI_CSR_EN_BIT];
      ctrl <= MRI_CTRL_RESET;
      base_data <= 16'h0000;
      status <= '0;
      mask <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      mme <= next_mme;
      msi_enable <= next_msi_enable;
      ctrl <= next_ctrl;
      base_data <= next_base_data;
      status <= next_status;
      mask <= next_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------------
  // Message request handshake
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_cur = cur;
    next_ack = 1'b0;
    next_msg_valid = 1'b0;
    next_msg_data = msg_data;
    next_msg_tc = msg_tc;
    next_last = last;
    next_pm_pend = pm_pend;
    next_serr_pend = serr_pend;
    clip_evt = 1'b0;
    vec_clipped = irq_msg_vector & alloc_mask;
    unique case (state)
      MRI_IDLE:
      begin
        // Internal sources go first; they are rare and time critical.
        if (serr_pend && msi_enable)
        begin
          next_cur.vector = 5'h1f & alloc_mask;
          next_cur.tc = MRI_TC_ZERO;
          next_cur.src = MRI_SRC_SERR;
          next_serr_pend = 1'b0;
          next_state = MRI_SEND;
        end
        else if (pm_pend && msi_enable)
        begin
          next_cur.vector = irq_pm_vector & alloc_mask;
          next_cur.tc = MRI_TC_ZERO;
          next_cur.src = MRI_SRC_PM;
          next_pm_pend = 1'b0;
          next_state = MRI_SEND;
        end
        else if (irq_msg_req && msi_enable && ctrl[MRI_CTRL_GIE_BIT])
        begin
          // vector offset, masked to the allocated vector count
          next_cur.vector = vec_clipped;
          next_cur.tc = irq_msg_traffic_class;
          next_cur.src = MRI_SRC_APP;
          clip_evt = (vec_clipped != irq_msg_vector);
          next_state = MRI_SEND;
        end
      end
      MRI_SEND:
      begin
        next_msg_valid = 1'b1;
        next_msg_data = {16'h0000, base_data | {11'h000, cur.vector}};
        next_msg_tc = cur.tc;
        next_last = cur;
        if (cur.src == MRI_SRC_APP)
        begin
          next_ack = 1'b1;
          next_state = MRI_ACK;
        end
        else
        begin
          next_state = MRI_IDLE;
        end
      end
      MRI_ACK:
      begin
        next_state = MRI_WAIT_DROP;
      end
      MRI_WAIT_DROP:
      begin
        if (!irq_msg_req)
        begin
          next_state = MRI_IDLE;
        end
      end
    endcase
    // A software pulse wins over a take in the same cycle, so none is lost.
    if (wr_en && paddr == MRI_OFF_CTRL)
    begin
      next_pm_pend = next_pm_pend | pwdata[MRI_CTRL_PM_BIT];
      next_serr_pend = next_serr_pend | pwdata[MRI_CTRL_SERR_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= MRI_IDLE;
      cur <= '0;
      irq_msg_ack <= 1'b0;
      msg_valid <= 1'b0;
      msg_data <= 32'h0000_0000;
      msg_tc <= MRI_TC_ZERO;
      last <= '0;
      pm_pend <= 1'b0;
      serr_pend <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cur <= next_cur;
      irq_msg_ack <= next_ack;
      msg_valid <= next_msg_valid;
      msg_data <= next_msg_data;
      msg_tc <= next_msg_tc;
      last <= next_last;
      pm_pend <= next_pm_pend;
      serr_pend <= next_serr_pend;
    end
  end

  // ----------------------------------------------------------------------
  // Control/status export and legacy messages
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_csr = 16'h0000;
    next_csr[MRI_CSR_PVM_BIT] = MRI_PVM_CAPABLE;
    next_csr[MRI_CSR_A64_BIT] = MRI_A64_CAPABLE;
    next_csr[MRI_CSR_MME_LSB +: 3] = mme;
    next_csr[MRI_CSR_MMC_LSB +: 3] = MRI_MMC_REQUESTED;
    next_csr[MRI_CSR_EN_BIT] = msi_enable;
    next_leg_valid = leg_sync ^ leg_prev;
    next_leg_assert = leg_sync;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      msg_interrupt_control_status <= MRI_CSR_RESET;
      leg_prev <= 1'b0;
      legacy_msg_valid <= 1'b0;
      legacy_msg_assert <= 1'b0;
    end
    else
    begin
      msg_interrupt_control_status <= next_csr;
      leg_prev <= leg_sync;
      legacy_msg_valid <= next_leg_valid;
      legacy_msg_assert <= next_leg_assert;
    end
  end

endmodule // mri_core

// [mri_core_props.sv]
// Port assertions for the message interrupt request block.
`timescale 1ns/1ps
module mri_core_props
  import mri_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic irq_msg_req,
  input wire logic [2:0] irq_msg_traffic_class,
  input wire logic irq_msg_ack,
  input wire logic [15:0] msg_interrupt_control_status,
  input wire logic msg_valid,
  input wire logic [31:0] msg_data,
  input wire logic [2:0] msg_tc,
  input wire logic irq_legacy_status,
  input wire logic legacy_msg_valid,
  input wire logic legacy_msg_assert
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ack_after_req: assert property (
    irq_msg_ack |-> $past(irq_msg_req) && irq_msg_req)
    else $error("ack without a held request");
  a_ack_single: assert property (
    irq_msg_ack |=> !irq_msg_ack)
    else $error("ack longer than one cycle");
  a_ack_tc_used: assert property (
    irq_msg_ack |-> msg_valid && msg_tc == irq_msg_traffic_class)
    else $error("message class differs from request");
  a_internal_tc0: assert property (
    msg_valid && !irq_msg_ack |-> msg_tc == MRI_TC_ZERO)
    else $error("internal message not on class zero");
  a_csr_caps: assert property (
    $past(presetn, 2) |-> msg_interrupt_control_status[15:7] == 9'h003)
    else $error("capability bits wrong");
  a_csr_request: assert property (
    $past(presetn, 2) |->
      msg_interrupt_control_status[3:1] == MRI_MMC_REQUESTED)
    else $error("requested count wrong");
  a_alloc_legal: assert property (
    msg_interrupt_control_status[6:4] != 3'h7)
    else $error("reserved allocation shown");
  a_vector_alloc: assert property (
    msg_valid && msg_interrupt_control_status[6:4] < 3'h5 |->
      (msg_data[4:0] >> msg_interrupt_control_status[6:4]) == 5'h00)
    else $error("vector outside allocation");
  a_legacy_msg: assert property (
    $rose(irq_legacy_status) |->
      ##[2:4] (legacy_msg_valid && legacy_msg_assert))
    else $error("legacy assert message missing");
endmodule // mri_core_props
bind mri_core mri_core_props mri_core_props_inst (
  .pclk(pclk),
  .presetn(presetn),
  .irq_msg_req(irq_msg_req),
  .irq_msg_traffic_class(irq_msg_traffic_class),
  .irq_msg_ack(irq_msg_ack),
  .msg_interrupt_control_status(msg_interrupt_control_status),
  .msg_valid(msg_valid),
  .msg_data(msg_data),
  .msg_tc(msg_tc),
  .irq_legacy_status(irq_legacy_status),
  .legacy_msg_valid(legacy_msg_valid),
  .legacy_msg_assert(legacy_msg_assert)
);

// [mri_app_model.sv]
// Application-side model that raises message interrupt requests.
`timescale 1ns/1ps
module mri_app_model
  import mri_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [4:0] num,
  input wire logic [2:0] cls,
  input wire logic [3:0] gap,
  input wire logic irq_msg_ack,
  output logic irq_msg_req,
  output logic [4:0] irq_msg_vector,
  output logic [2:0] irq_msg_traffic_class
);
  logic busy;
  logic [3:0] cnt;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {busy, cnt, irq_msg_req} <= '0;
      irq_msg_vector <= '1;
      irq_msg_traffic_class <= '1;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      cnt <= gap;
    end
    else if (busy && !irq_msg_req && cnt == 4'h0)
    begin
      irq_msg_req <= 1'b1;
      irq_msg_vector <= num;
      irq_msg_traffic_class <= cls;
    end
    else if (busy && !irq_msg_req)
      cnt <= cnt - 4'h1;
    else if (irq_msg_ack)
    begin
      // Released fields flip so a late sample cannot pass.
      irq_msg_req <= 1'b0;
      irq_msg_vector <= ~irq_msg_vector;
      irq_msg_traffic_class <= ~irq_msg_traffic_class;
      busy <= 1'b0;
    end
  end
endmodule // mri_app_model

// [testbench.sv]
// Self-checking bench for the message interrupt request block.
`timescale 1ns/1ps
module testbench;
  import mri_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, msg_data, rd, r, base, exp_d;
  logic pready, pslverr, irq_msg_req, irq_msg_ack, msg_valid, err;
  logic legacy_msg_valid, legacy_msg_assert, irq, start = 0;
  logic irq_legacy_status = 0;
  logic [2:0] irq_msg_traffic_class, msg_tc, cls = 0, exp_t;
  logic [4:0] irq_msg_vector, num = 0, irq_pm_vector = 0, msk;
  logic [3:0] gap = 0;
  logic [15:0] msg_interrupt_control_status;
  logic [31:0] seed = 32'h7602ab77;
  int miscompares = 0, n_tests = 0, n_msg = 0, n_leg = 0, alloc = 0, n0 = 0;
  always #12.5 pclk = ~pclk;
  mri_core mri_core_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq_msg_req(irq_msg_req),
    .irq_msg_traffic_class(irq_msg_traffic_class),
    .irq_msg_vector(irq_msg_vector),
    .irq_pm_vector(irq_pm_vector),
    .irq_legacy_status(irq_legacy_status),
    .irq_msg_ack(irq_msg_ack),
    .msg_interrupt_control_status(msg_interrupt_control_status),
    .msg_valid(msg_valid),
    .msg_data(msg_data),
    .msg_tc(msg_tc),
    .legacy_msg_valid(legacy_msg_valid),
    .legacy_msg_assert(legacy_msg_assert),
    .irq(irq)
  );
  mri_app_model mri_app_model_inst (
    .pclk(pclk),
    .presetn(presetn),
    .start(start),
    .num(num),
    .cls(cls),
    .gap(gap),
    .irq_msg_ack(irq_msg_ack),
    .irq_msg_req(irq_msg_req),
    .irq_msg_vector(irq_msg_vector),
    .irq_msg_traffic_class(irq_msg_traffic_class)
  );
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("miscompares %0d n_tests %0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The request stands until pready is sampled high at a rising edge;
    // the answer is taken at that same edge and only then released.
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      miscompares++;
      stop_test;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic hold(ref int c, input int n);
    int i;
    for (i = 0; i < 60 && c != n; i++)
      @(negedge pclk);
    chk(c, n);
    if (c != n)
      stop_test;
  endtask
  task automatic send(input logic [4:0] v, input logic [2:0] t);
    exp_d = base | v;
    exp_t = t;
    @(posedge pclk);
    num <= v;
    cls <= t;
    gap <= r[12:9];
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    hold(n_msg, n_msg + 1);
  endtask
  task automatic intern(input logic [31:0] b, input logic [4:0] v);
    exp_d = base | v;
    exp_t = MRI_TC_ZERO;
    bus(1'b1, MRI_OFF_CTRL, b);
    hold(n_msg, n_msg + 1);
  endtask
  always @(negedge pclk)
  begin
    if (msg_valid === 1'b1)
    begin
      n_msg++;
      chk(msg_data, exp_d);
      chk(msg_tc, exp_t);
    end
    if (legacy_msg_valid === 1'b1)
    begin
      n_leg++;
      chk(legacy_msg_assert, irq_legacy_status);
    end
  end
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    bus(1'b0, MRI_OFF_CSR, 0);
    chk(rd, 32'h186);
    bus(1'b0, MRI_OFF_CTRL, 0);
    chk(rd, MRI_CTRL_RESET);
    bus(1'b0, 12'h018, 0);
    chk(err, 1'b1);
    bus(1'b1, MRI_OFF_LAST, 0);
    chk(err, 1'b1);
    r = rnd();
    base = {16'h0, r[15:5], 5'h00};
    bus(1'b1, MRI_OFF_MSGDATA, base);
    bus(1'b1, MRI_OFF_MASK, 32'h1);
    for (int a = 0; a < 8; a++)
    begin
      if (a != 7)
        alloc = a;
      msk = (alloc > 4) ? 5'h1f : 5'((1 << alloc) - 1);
      bus(1'b1, MRI_OFF_CSR, 32'(a << 4) | 32'h1);
      bus(1'b0, MRI_OFF_CSR, 0);
      chk(rd, 32'h187 | 32'(alloc << 4));
      r = rnd();
      send(r[8:4] & msk, r[2:0]);
      bus(1'b0, MRI_OFF_STATUS, 0);
      chk(rd, 32'h1);
      chk(irq, 1'b1);
      bus(1'b1, MRI_OFF_STATUS, 32'h1);
      bus(1'b0, MRI_OFF_STATUS, 0);
      chk(rd, 32'h0);
      chk(irq, 1'b0);
      irq_pm_vector <= r[20:16];
      intern(32'h5, r[20:16] & msk);
      intern(32'h6, msk);
      bus(1'b1, MRI_OFF_STATUS, 32'hf);
    end
    irq_legacy_status <= 1'b1;
    hold(n_leg, 1);
    bus(1'b0, MRI_OFF_STATUS, 0);
    chk(rd, 32'h2);
    irq_legacy_status <= 1'b0;
    hold(n_leg, 2);
    bus(1'b0, MRI_OFF_STATUS, 0);
    chk(rd, 32'h6);
    // a request waits while the global enable is off
    bus(1'b1, MRI_OFF_CTRL, 32'h0);
    n0 = n_msg;
    exp_d = base | r[25:21];
    exp_t = r[31:29];
    num <= r[25:21];
    cls <= r[31:29];
    gap <= 4'h0;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    repeat (20) @(posedge pclk);
    chk(n_msg, n0);
    bus(1'b1, MRI_OFF_CTRL, MRI_CTRL_RESET);
    hold(n_msg, n0 + 1);
    stop_test;
  end
endmodule // testbench
